// ---- logic/gpx_pkg.sv ----
// Package for the pin configuration and indexed data access block
// ==========================================================================
// Functional notes
// - Run-state index/data access answers only while the global run-access bit is one.
// - After power-on the index port sits at 0xEA and the data port at 0xEB.
// - The index port may only move to 0xE0, 0xE2, 0xE4 or 0xEA.
// - The data port is always the index port address plus one.
// - A new port location takes effect once configuration state is left.
// - Index 0x01, 0x03, 0x05, 0x06 select bank A, watchdog, bank B, bank C.
// - Index 0x08/0x09 select soft-power enables, 0x0A/0x0B soft-power status.
// - Run-state registers share storage with their logical unit eight registers.
// - Per-pin configuration registers are reachable in configuration state only.
// - For the plain pin function bit 0 one means input, zero output.
// - Bit 1 one inverts pin versus data bit for inputs and outputs.
// - Bits 4:3 select the pin function; 00 selects the default function.
// - Bit 5 enables the pin into its group interrupt in every function.
// - Bit 7 chooses open-drain or push-pull for plain and capable alternate outputs.
// - With an alternate function the direction comes from the function, bit 0 ignored.
// - Alternate outputs invert with bit 1; inputs do not, except either-edge input.
// - Each group interrupt is the OR of its enabled pins, active high.
// - A group interrupt select register picks each group's host channel.
// - Both group interrupts also feed SMI, wake-up and SCI/PME event routing.
// - Per-group debounce rejects input pulses of 1 ms or shorter.
// - An unselected alternate input sits at its inactive level, chip select at one.
// - Reading an input data bit returns the pin level; writing it does nothing.
// - An output data bit drives the pin; reading returns the last value written.
// - At power-on reset every pin is a non-inverting input.
package gpx_pkg;
  localparam int NPIN = 24;
  localparam int NALT = 4;
  localparam int CNT_W = 14;
  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int DEB_TIME_NS = 1000000;
  localparam int DEB_CYCLES_DOC = DEB_TIME_NS / CLK_PERIOD_NS;
  // ==========================================================================
  // Run-state ports and indices
  localparam logic [7:0] IDX_BASE_RST = 8'hea;
  localparam logic [7:0] IDX_BASE_E0 = 8'he0;
  localparam logic [7:0] IDX_BASE_E2 = 8'he2;
  localparam logic [7:0] IDX_BASE_E4 = 8'he4;
  localparam logic [7:0] RIDX_BANK_A = 8'h01;
  localparam logic [7:0] RIDX_WDT = 8'h03;
  localparam logic [7:0] RIDX_BANK_B = 8'h05;
  localparam logic [7:0] RIDX_BANK_C = 8'h06;
  localparam logic [7:0] RIDX_SPE1 = 8'h08;
  localparam logic [7:0] RIDX_SPE2 = 8'h09;
  localparam logic [7:0] RIDX_SPS1 = 8'h0a;
  localparam logic [7:0] RIDX_SPS2 = 8'h0b;
  // ==========================================================================
  // Logical unit eight register numbers
  localparam logic [7:0] CR_BANK_A = 8'hf6;
  localparam logic [7:0] CR_WDT = 8'hf4;
  localparam logic [7:0] CR_BANK_B = 8'hf9;
  localparam logic [7:0] CR_BANK_C = 8'hfa;
  localparam logic [7:0] CR_SPE1 = 8'hb0;
  localparam logic [7:0] CR_SPE2 = 8'hb1;
  localparam logic [7:0] CR_SPS1 = 8'hb2;
  localparam logic [7:0] CR_SPS2 = 8'hb3;
  localparam logic [7:0] CR_GINT1 = 8'hf7;
  localparam logic [7:0] CR_GINT2 = 8'hf8;
  localparam logic [7:0] CR_CFG_A = 8'he0;
  localparam logic [7:0] CR_CFG_B = 8'hc8;
  localparam logic [7:0] CR_CFG_C = 8'hd0;
  localparam logic [7:0] BANK_B_IMPL = 8'h1d;
  // ==========================================================================
  // Pin configuration fields
  localparam int CB_DIR = 0;
  localparam int CB_POL = 1;
  localparam int CB_FN_LO = 3;
  localparam int CB_IEN = 5;
  localparam int CB_OD = 7;
  localparam logic [7:0] CFG_RST = 8'h01;
  localparam int GI_DEB = 4;
  localparam logic [7:0] GINT_RST = 8'h00;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } gpx_io_req_t;

  typedef struct packed {
    logic sel;
    logic rd;
    logic wr;
    logic [7:0] idx;
    logic [7:0] wdata;
  } gpx_cfg_req_t;

  typedef struct packed {
    logic [NPIN-1:0][7:0] cfg;
    logic [NPIN-1:0] dout;
    logic [NPIN-1:0] filt;
    logic [NPIN-1:0][CNT_W-1:0] cnt;
    logic [7:0] wdt;
    logic [7:0] spe1;
    logic [7:0] spe2;
    logic [7:0] sps1;
    logic [7:0] sps2;
    logic [7:0] gint1;
    logic [7:0] gint2;
    logic [7:0] run_base;
    logic [7:0] run_idx;
    logic cfg_prev;
    logic [7:0] io_rdata;
    logic io_rack;
    logic [7:0] cfg_rdata;
    logic cfg_rack;
    logic [NPIN-1:0] pin_o;
    logic [NPIN-1:0] pin_oe;
    logic [NALT-1:0][NPIN-1:0] alt_in;
    logic [1:0] grp_irq;
    logic [1:0] grp_evt;
  } gpx_state_t;
endpackage : gpx_pkg

// ---- logic/gpx_top.sv ----
// Pin configuration, group interrupts and run-state indexed register access
`timescale 1ns/1ps
`default_nettype none
module gpx_top #(
  parameter int DEB_CYCLES = gpx_pkg::DEB_CYCLES_DOC,
  parameter logic [gpx_pkg::NPIN-1:0][1:0] PLAIN_FN = 48'haaaa_aa9a_0000,
  parameter logic [gpx_pkg::NPIN-1:0] GROUP2_MASK = 24'hffff00,
  parameter logic [gpx_pkg::NALT-1:0][gpx_pkg::NPIN-1:0] ALT_IS_OUT = 96'h0,
  parameter logic [gpx_pkg::NALT-1:0][gpx_pkg::NPIN-1:0] ALT_IS_EITHER_EDGE_IRQ_INPUT = 96'h0,
  parameter logic [gpx_pkg::NALT-1:0][gpx_pkg::NPIN-1:0] ALT_OD_OK = 96'h0,
  parameter logic [gpx_pkg::NALT-1:0][gpx_pkg::NPIN-1:0] ALT_IDLE = 96'h0000_0000_0000_0000_0000_0800
) (
  input wire logic CLK, // 10 MHz clock
  input wire logic RSTN, // Battery power-on reset
  input wire logic RUN_EN, // Global run-access bit
  input wire logic CFG_MODE, // Chip in configuration state
  input wire logic [7:0] IDX_BASE, // Programmed index port location
  input wire gpx_pkg::gpx_io_req_t IO_REQ, // Host I/O cycle
  output logic [7:0] IO_RDATA, // Run-state read data
  output logic IO_RACK, // Run-state read answered
  input wire gpx_pkg::gpx_cfg_req_t CFG_REQ, // Unit eight register access
  output logic [7:0] CFG_RDATA, // Configuration read data
  output logic CFG_RACK, // Configuration read answered
  input wire logic [gpx_pkg::NPIN-1:0] PIN_I, // Pin levels
  output logic [gpx_pkg::NPIN-1:0] PIN_O, // Pin drive values
  output logic [gpx_pkg::NPIN-1:0] PIN_OE, // Pin drive enables
  input wire logic [gpx_pkg::NALT-1:0][gpx_pkg::NPIN-1:0] ALT_OUT, // Alternate sources
  output logic [gpx_pkg::NALT-1:0][gpx_pkg::NPIN-1:0] ALT_IN, // Alternate inputs
  output logic [1:0] GRP_IRQ, // Group interrupt levels
  output logic [1:0] GRP_EVT, // Group rising-edge events
  output logic [3:0] GRP1_CHAN, // Group 1 host channel
  output logic [3:0] GRP2_CHAN, // Group 2 host channel
  output logic [7:0] WDT_CTRL, // Watchdog control value
  output logic [15:0] SP_ENABLE, // Soft-power enables
  output logic [15:0] SP_STATUS // Soft-power status
);
  import gpx_pkg::*;

  if (DEB_CYCLES < 2 || DEB_CYCLES >= (1 << CNT_W)) begin : g_chk
    $error("DEB_CYCLES out of counter range");
  end

  localparam logic [CNT_W-1:0] DEB_LIM = CNT_W'(DEB_CYCLES);

  gpx_state_t st_r;
  gpx_state_t st_nxt;

  // ==========================================================================
  // Decode helpers
  function automatic logic base_ok(input logic [7:0] b);
    base_ok = (b == IDX_BASE_E0) || (b == IDX_BASE_E2) ||
              (b == IDX_BASE_E4) || (b == IDX_BASE_RST);
  endfunction : base_ok

  // Run index to shared unit eight number; zero means unmapped
  function automatic logic [7:0] run2cr(input logic [7:0] idx);
    case (idx)
      RIDX_BANK_A: run2cr = CR_BANK_A;
      RIDX_WDT: run2cr = CR_WDT;
      RIDX_BANK_B: run2cr = CR_BANK_B;
      RIDX_BANK_C: run2cr = CR_BANK_C;
      RIDX_SPE1: run2cr = CR_SPE1;
      RIDX_SPE2: run2cr = CR_SPE2;
      RIDX_SPS1: run2cr = CR_SPS1;
      RIDX_SPS2: run2cr = CR_SPS2;
      default: run2cr = 8'h00;
    endcase
  endfunction : run2cr

  // Pin configuration register number to pin; bit 5 flags a hit
  function automatic logic [5:0] cr2pin(input logic [7:0] cr);
    cr2pin = 6'h00;
    if (cr[7:3] == CR_CFG_A[7:3]) begin
      cr2pin = {1'b1, 5'(cr[2:0])};
    end else if (cr[7:3] == CR_CFG_B[7:3] && BANK_B_IMPL[cr[2:0]]) begin
      cr2pin = {1'b1, 5'(cr[2:0]) + 5'h08};
    end else if (cr[7:3] == CR_CFG_C[7:3]) begin
      cr2pin = {1'b1, 5'(cr[2:0]) + 5'h10};
    end
  endfunction : cr2pin

  // ==========================================================================
  // Per-pin datapath
  logic [NPIN-1:0] plain;
  logic [NPIN-1:0] is_out;
  logic [NPIN-1:0] oval;
  logic [NPIN-1:0] od_en;
  logic [NPIN-1:0] raw_in;
  logic [NPIN-1:0] rd_bit;
  logic [NPIN-1:0] irq_src;
  logic [1:0] fn [NPIN];

  always_comb begin
    for (int p = 0; p < NPIN; p++) begin
      fn[p] = st_r.cfg[p][CB_FN_LO +: 2];
      plain[p] = (fn[p] == PLAIN_FN[p]);
      raw_in[p] = PIN_I[p] ^ st_r.cfg[p][CB_POL];
      if (plain[p]) begin
        is_out[p] = ~st_r.cfg[p][CB_DIR];
        oval[p] = st_r.dout[p] ^ st_r.cfg[p][CB_POL];
        od_en[p] = st_r.cfg[p][CB_OD];
        rd_bit[p] = is_out[p] ? st_r.dout[p] : raw_in[p];
      end else begin
        is_out[p] = ALT_IS_OUT[fn[p]][p];
        oval[p] = ALT_OUT[fn[p]][p] ^ st_r.cfg[p][CB_POL];
        od_en[p] = st_r.cfg[p][CB_OD] & ALT_OD_OK[fn[p]][p];
        rd_bit[p] = raw_in[p];
      end
      // Debounce only guards pins that are sensed as inputs
      if (is_out[p]) begin
        irq_src[p] = st_r.cfg[p][CB_IEN] & oval[p];
      end else if (GROUP2_MASK[p] ? st_r.gint2[GI_DEB] : st_r.gint1[GI_DEB]) begin
        irq_src[p] = st_r.cfg[p][CB_IEN] & st_r.filt[p];
      end else begin
        irq_src[p] = st_r.cfg[p][CB_IEN] & raw_in[p];
      end
    end
  end

  // Bank read assembly; unimplemented bank B bits read zero
  function automatic logic [7:0] bank_rd(input logic [NPIN-1:0] b, input int k);
    bank_rd = b[k*8 +: 8];
    if (k == 1) begin
      bank_rd = bank_rd & BANK_B_IMPL;
    end
  endfunction : bank_rd

  function automatic logic [7:0] reg_rd(input gpx_state_t s, input logic [7:0] cr,
                                        input logic [NPIN-1:0] bits);
    logic [5:0] pn;
    pn = cr2pin(cr);
    case (cr)
      CR_BANK_A: reg_rd = bank_rd(bits, 0);
      CR_BANK_B: reg_rd = bank_rd(bits, 1);
      CR_BANK_C: reg_rd = bank_rd(bits, 2);
      CR_WDT: reg_rd = s.wdt;
      CR_SPE1: reg_rd = s.spe1;
      CR_SPE2: reg_rd = s.spe2;
      CR_SPS1: reg_rd = s.sps1;
      CR_SPS2: reg_rd = s.sps2;
      CR_GINT1: reg_rd = s.gint1;
      CR_GINT2: reg_rd = s.gint2;
      default: reg_rd = pn[5] ? s.cfg[pn[4:0]] : 8'h00;
    endcase
  endfunction : reg_rd

  // ==========================================================================
  // Register access and next state
  logic run_ok;
  logic idx_hit;
  logic dat_hit;
  logic wr_en;
  logic [7:0] wr_cr;
  logic [7:0] wr_val;
  logic [5:0] wr_pin;
  logic raw_irq1;
  logic raw_irq2;

  always_comb begin
    st_nxt = st_r;
    run_ok = RUN_EN & ~CFG_MODE;
    idx_hit = run_ok && IO_REQ.addr == {8'h00, st_r.run_base};
    dat_hit = run_ok && IO_REQ.addr == {8'h00, st_r.run_base + 8'h01};
    wr_en = 1'b0;
    wr_cr = 8'h00;
    wr_val = CFG_REQ.wdata;
    if (idx_hit && IO_REQ.wr) begin
      st_nxt.run_idx = IO_REQ.wdata;
    end
    if (dat_hit && IO_REQ.wr) begin
      wr_en = 1'b1;
      wr_cr = run2cr(st_r.run_idx);
      wr_val = IO_REQ.wdata;
    end else if (CFG_MODE && CFG_REQ.sel && CFG_REQ.wr) begin
      wr_en = 1'b1;
      wr_cr = CFG_REQ.idx;
    end
    wr_pin = cr2pin(wr_cr);
    st_nxt.io_rack = (idx_hit | dat_hit) & IO_REQ.rd;
    st_nxt.io_rdata = 8'h00;
    if (idx_hit && IO_REQ.rd) begin
      st_nxt.io_rdata = st_r.run_idx;
    end else if (dat_hit && IO_REQ.rd) begin
      st_nxt.io_rdata = reg_rd(st_r, run2cr(st_r.run_idx), rd_bit);
    end
    st_nxt.cfg_rack = CFG_MODE & CFG_REQ.sel & CFG_REQ.rd;
    st_nxt.cfg_rdata = st_nxt.cfg_rack ? reg_rd(st_r, CFG_REQ.idx, rd_bit) : 8'h00;
    if (wr_en) begin
      case (wr_cr)
        CR_BANK_A: st_nxt.dout[7:0] = wr_val;
        CR_BANK_B: st_nxt.dout[15:8] = wr_val & BANK_B_IMPL;
        CR_BANK_C: st_nxt.dout[23:16] = wr_val;
        CR_WDT: st_nxt.wdt = wr_val;
        CR_SPE1: st_nxt.spe1 = wr_val;
        CR_SPE2: st_nxt.spe2 = wr_val;
        CR_SPS1: st_nxt.sps1 = wr_val;
        CR_SPS2: st_nxt.sps2 = wr_val;
        CR_GINT1: st_nxt.gint1 = wr_val;
        CR_GINT2: st_nxt.gint2 = wr_val;
        default: begin
          if (wr_pin[5] && CFG_MODE) begin
            st_nxt.cfg[wr_pin[4:0]] = wr_val;
          end
        end
      endcase
      // Input pins keep their latch untouched by data writes
      for (int p = 0; p < NPIN; p++) begin
        if (!(plain[p] && is_out[p])) begin
          st_nxt.dout[p] = st_r.dout[p];
        end
      end
    end
    // Relocation is applied only on the way out of configuration state
    st_nxt.cfg_prev = CFG_MODE;
    if (st_r.cfg_prev && !CFG_MODE && base_ok(IDX_BASE)) begin
      st_nxt.run_base = IDX_BASE;
    end
    // Debounce: a level must differ for more than DEB_CYCLES cycles
    for (int p = 0; p < NPIN; p++) begin
      if (raw_in[p] == st_r.filt[p]) begin
        st_nxt.cnt[p] = '0;
      end else if (st_r.cnt[p] == DEB_LIM) begin
        st_nxt.cnt[p] = '0;
        st_nxt.filt[p] = raw_in[p];
      end else begin
        st_nxt.cnt[p] = st_r.cnt[p] + CNT_W'(1);
      end
    end
    for (int p = 0; p < NPIN; p++) begin
      st_nxt.pin_oe[p] = is_out[p] & ~(od_en[p] & oval[p]);
      st_nxt.pin_o[p] = oval[p] & ~od_en[p];
      for (int s = 0; s < NALT; s++) begin
        if (!plain[p] && fn[p] == 2'(s) && !ALT_IS_OUT[s][p]) begin
          st_nxt.alt_in[s][p] = ALT_IS_EITHER_EDGE_IRQ_INPUT[s][p] ? raw_in[p] : PIN_I[p];
        end else begin
          st_nxt.alt_in[s][p] = ALT_IDLE[s][p];
        end
      end
    end
    raw_irq1 = |(irq_src & ~GROUP2_MASK);
    raw_irq2 = |(irq_src & GROUP2_MASK);
    st_nxt.grp_irq = {raw_irq2, raw_irq1};
    st_nxt.grp_evt = st_nxt.grp_irq & ~st_r.grp_irq;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= '0;
      st_r.cfg <= {NPIN{CFG_RST}};
      st_r.run_base <= IDX_BASE_RST;
      st_r.gint1 <= GINT_RST;
      st_r.gint2 <= GINT_RST;
      st_r.alt_in <= ALT_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign IO_RDATA = st_r.io_rdata;
  assign IO_RACK = st_r.io_rack;
  assign CFG_RDATA = st_r.cfg_rdata;
  assign CFG_RACK = st_r.cfg_rack;
  assign PIN_O = st_r.pin_o;
  assign PIN_OE = st_r.pin_oe;
  assign ALT_IN = st_r.alt_in;
  assign GRP_IRQ = st_r.grp_irq;
  assign GRP_EVT = st_r.grp_evt;
  assign GRP1_CHAN = st_r.gint1[3:0];
  assign GRP2_CHAN = st_r.gint2[3:0];
  assign WDT_CTRL = st_r.wdt;
  assign SP_ENABLE = {st_r.spe2, st_r.spe1};
  assign SP_STATUS = {st_r.sps2, st_r.sps1};

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  sequence s_idx_wr(logic [7:0] v);
    IO_REQ.wr && RUN_EN && !CFG_MODE && IO_REQ.addr == {8'h00, st_r.run_base}
      && IO_REQ.wdata == v;
  endsequence

  sequence s_dat_wr;
    IO_REQ.wr && RUN_EN && !CFG_MODE && !CFG_REQ.wr
      && IO_REQ.addr == {8'h00, st_r.run_base + 8'h01};
  endsequence

  property p_run_gate;
    !RUN_EN |=> $stable(st_r.run_idx) && !IO_RACK;
  endproperty
  a_run_gate: assert property (p_run_gate) else $error("Run access while disabled");

  property p_base_legal;
    base_ok(st_r.run_base);
  endproperty
  a_base_legal: assert property (p_base_legal) else $error("Illegal index port");

  property p_data_port;
    IO_REQ.rd && RUN_EN && !CFG_MODE && IO_REQ.addr == {8'h00, st_r.run_base + 8'h01}
      |=> IO_RACK;
  endproperty
  a_data_port: assert property (p_data_port) else $error("Data port not answered");

  property p_base_hold;
    CFG_MODE |=> $stable(st_r.run_base);
  endproperty
  a_base_hold: assert property (p_base_hold) else $error("Port moved in config state");

  property p_wdt_path;
    logic [7:0] d;
    s_idx_wr(RIDX_WDT) ##1 !IO_REQ.wr ##1 (s_dat_wr, d = IO_REQ.wdata) |=> st_r.wdt == d;
  endproperty
  a_wdt_path: assert property (p_wdt_path) else $error("Watchdog index failed");

  property p_spe_path;
    logic [7:0] d;
    s_idx_wr(RIDX_SPE1) ##1 !IO_REQ.wr ##1 (s_dat_wr, d = IO_REQ.wdata) |=> SP_ENABLE[7:0] == d;
  endproperty
  a_spe_path: assert property (p_spe_path) else $error("Soft-power index failed");

  property p_cfg_locked;
    !CFG_MODE |=> $stable(st_r.cfg);
  endproperty
  a_cfg_locked: assert property (p_cfg_locked) else $error("Pin config changed in run");

  property p_pin0_out;
    plain[0] && !st_r.cfg[0][CB_DIR] && !st_r.cfg[0][CB_OD]
      |=> PIN_OE[0] && PIN_O[0] == $past(st_r.dout[0] ^ st_r.cfg[0][CB_POL]);
  endproperty
  a_pin0_out: assert property (p_pin0_out) else $error("Pin 0 output wrong");

  property p_grp1;
    1'b1 |=> GRP_IRQ[0] == $past(|(irq_src & ~GROUP2_MASK));
  endproperty
  a_grp1: assert property (p_grp1) else $error("Group 1 interrupt wrong");

  property p_evt;
    GRP_EVT[1] == $rose(GRP_IRQ[1]);
  endproperty
  a_evt: assert property (p_evt) else $error("Group event without level");

  sequence s_cfg_rd(logic [7:0] r);
    CFG_MODE && CFG_REQ.sel && CFG_REQ.rd && CFG_REQ.idx == r;
  endsequence

  property p_cfg_path;
    s_cfg_rd(CR_WDT) |=> CFG_RACK && CFG_RDATA == $past(WDT_CTRL);
  endproperty
  a_cfg_path: assert property (p_cfg_path) else $error("Shared watchdog read wrong");

  property p_cfg_gate;
    !CFG_MODE |=> !CFG_RACK;
  endproperty
  a_cfg_gate: assert property (p_cfg_gate) else $error("Config answered in run");

  property p_od_pin1;
    plain[1] && !st_r.cfg[1][CB_DIR] && st_r.cfg[1][CB_OD] |=> !PIN_O[1];
  endproperty
  a_od_pin1: assert property (p_od_pin1) else $error("Open drain drives high");

  property p_in_wr;
    plain[16] && st_r.cfg[16][CB_DIR] |=> $stable(st_r.dout[16]);
  endproperty
  a_in_wr: assert property (p_in_wr) else $error("Input data bit written");

  property p_alt_idle;
    st_r.cfg[11][CB_FN_LO +: 2] != 2'b00 |=> ALT_IN[0][11] == ALT_IDLE[0][11];
  endproperty
  a_alt_idle: assert property (p_alt_idle) else $error("Unselected input active");
endmodule : gpx_top
`default_nettype wire

// ---- tb/gpx_host_model.sv ----
// Host bus master model issuing run-state I/O cycles and unit eight register cycles
`timescale 1ns/1ps
`default_nettype none
module gpx_host_model (
  input wire logic clk, // Bus clock
  output var gpx_pkg::gpx_io_req_t io_req, // Run-state I/O cycle
  output var gpx_pkg::gpx_cfg_req_t cfg_req, // Unit eight access
  input wire logic [7:0] io_rdata, // Run read data
  input wire logic io_rack, // Run read answer
  input wire logic [7:0] cfg_rdata, // Config read data
  input wire logic cfg_rack // Config read answer
);
  import gpx_pkg::*;
  initial begin
    io_req = '0;
    cfg_req = '0;
  end
  // ==========================================================================
  // Bus cycles
  // Idle bus shows the inverse of the last cycle, so a stale value never matches
  task automatic io_cyc(input logic [7:0] a, input logic rd, input logic [7:0] d,
                        output logic ack, output logic [7:0] q);
    @(posedge clk);
    io_req <= '{addr: {8'h00, a}, rd: rd, wr: ~rd, wdata: d};
    @(posedge clk);
    io_req <= '{addr: ~io_req.addr, rd: 1'b0, wr: 1'b0, wdata: ~d};
    #1;
    ack = io_rack;
    q = io_rdata;
  endtask : io_cyc
  task automatic run_acc(input logic [7:0] base, input logic [7:0] idx, input logic rd,
                         input logic [7:0] d, output logic ack, output logic [7:0] q);
    io_cyc(base, 1'b0, idx, ack, q);
    io_cyc(8'(base + 8'h01), rd, d, ack, q);
  endtask : run_acc
  task automatic cfg_cyc(input logic [7:0] idx, input logic rd, input logic [7:0] d,
                         output logic ack, output logic [7:0] q);
    @(posedge clk);
    cfg_req <= '{sel: 1'b1, rd: rd, wr: ~rd, idx: idx, wdata: d};
    @(posedge clk);
    cfg_req <= '{sel: 1'b0, rd: 1'b0, wr: 1'b0, idx: ~idx, wdata: ~d};
    #1;
    ack = cfg_rack;
    q = cfg_rdata;
  endtask : cfg_cyc
endmodule : gpx_host_model
`default_nettype wire

// ---- tb/gpx_top_tb.sv ----
// Self-checking bench for the pin configuration and indexed access block
`timescale 1ns/1ps
`default_nettype none
module gpx_top_tb;
  import gpx_pkg::*;
  typedef struct packed {
    logic [7:0] ridx;
    logic [7:0] wval;
    logic [7:0] rexp;
    logic [7:0] cr;
  } gpx_row_t;
  // Index, value written, value read back, unit eight register number
  localparam gpx_row_t ROWS [9] = '{32'h01a5a5f6, 32'h035a5af4, 32'h05ff14f9, 32'h06ff5afa,
    32'h081111b0, 32'h092222b1, 32'h0a3333b2, 32'h0b4444b3, 32'h02770000};
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic run_en = 1'b1;
  logic cfg_mode = 1'b0;
  logic [7:0] idx_base = 8'hea;
  logic [NPIN-1:0] pin_i = 24'h5a34c3;
  logic [NALT-1:0][NPIN-1:0] alt_out = '0;
  gpx_io_req_t io_req;
  gpx_cfg_req_t cfg_req;
  logic [7:0] io_rdata, cfg_rdata, wdt_ctrl, q;
  logic io_rack, cfg_rack, ack;
  logic [NPIN-1:0] pin_o, pin_oe;
  logic [NALT-1:0][NPIN-1:0] alt_in;
  logic [1:0] grp_irq, grp_evt;
  logic [3:0] grp1_chan, grp2_chan;
  logic [15:0] sp_enable, sp_status;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] n_evt;
  always #50 clk = ~clk;
  gpx_top #(.DEB_CYCLES(8), .ALT_IS_OUT(96'h0000_0000_0000_0008_0000_0000))
    dut_u (.CLK(clk), .RSTN(rstn), .RUN_EN(run_en),
    .CFG_MODE(cfg_mode), .IDX_BASE(idx_base), .IO_REQ(io_req), .IO_RDATA(io_rdata),
    .IO_RACK(io_rack), .CFG_REQ(cfg_req), .CFG_RDATA(cfg_rdata), .CFG_RACK(cfg_rack),
    .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe), .ALT_OUT(alt_out), .ALT_IN(alt_in),
    .GRP_IRQ(grp_irq), .GRP_EVT(grp_evt), .GRP1_CHAN(grp1_chan), .GRP2_CHAN(grp2_chan),
    .WDT_CTRL(wdt_ctrl), .SP_ENABLE(sp_enable), .SP_STATUS(sp_status));
  gpx_host_model host_u (.clk(clk), .io_req(io_req), .cfg_req(cfg_req), .io_rdata(io_rdata),
    .io_rack(io_rack), .cfg_rdata(cfg_rdata), .cfg_rack(cfg_rack));
  // ==========================================================================
  // Helpers
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic results();
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results
  task automatic setm(input logic m, input logic [7:0] b);
    @(posedge clk);
    cfg_mode <= m;
    idx_base <= b;
  endtask : setm
  task automatic cw(input logic [7:0] r, input logic [7:0] d);
    host_u.cfg_cyc(r, 1'b0, d, ack, q);
  endtask : cw
  // Long ceiling: the whole sequence needs well under two thousand cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      results();
    end
  end
  // ==========================================================================
  // Sequence
  initial begin
    repeat (20) @(posedge clk);
    chk(alt_in[0][11], 1'b1);
    chk(pin_oe, '0);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(alt_in[0][11], 1'b0);
    setm(1'b1, 8'hea);
    host_u.cfg_cyc(CR_CFG_A, 1'b1, 8'h00, ack, q);
    chk({ack, q}, {1'b1, CFG_RST});
    for (int i = 0; i < 8; i++) begin
      cw(8'(CR_CFG_A + i), 8'h00);
    end
    setm(1'b0, 8'hea);
    foreach (ROWS[i]) begin
      host_u.run_acc(8'hea, ROWS[i].ridx, 1'b0, ROWS[i].wval, ack, q);
      host_u.run_acc(8'hea, ROWS[i].ridx, 1'b1, 8'h00, ack, q);
      chk({ack, q}, {1'b1, ROWS[i].rexp});
      setm(1'b1, 8'hea);
      host_u.cfg_cyc(ROWS[i].cr, 1'b1, 8'h00, ack, q);
      chk({ack, q}, {1'b1, ROWS[i].rexp});
      setm(1'b0, 8'hea);
    end
    chk({sp_status, wdt_ctrl}, 24'h44335a);
    chk(sp_enable, 16'h2211);
    chk({pin_oe[7:0], pin_o[7:0]}, 16'hffa5);
    // Inverted output, open drain, interrupt source, inverted inputs, alternate output
    setm(1'b1, 8'hea);
    cw(CR_CFG_A, 8'h02);
    cw(8'(CR_CFG_A + 1), 8'h80);
    cw(8'(CR_CFG_A + 2), 8'h20);
    cw(CR_CFG_C, 8'h13);
    cw(8'(CR_CFG_C + 1), 8'h33);
    cw(8'hcb, 8'h0b);
    cw(CR_GINT1, 8'h05);
    cw(CR_GINT2, 8'h1a);
    setm(1'b0, 8'hea);
    repeat (3) @(posedge clk);
    #1;
    chk({pin_oe[2:0], pin_o[2:0]}, 6'b111100);
    chk(grp_irq, 2'b01);
    chk({grp2_chan, grp1_chan}, 8'ha5);
    chk(alt_in[0][11], 1'b1);
    chk({pin_oe[11], pin_o[11]}, 2'b11);
    host_u.run_acc(8'hea, RIDX_BANK_C, 1'b0, 8'hff, ack, q);
    host_u.run_acc(8'hea, RIDX_BANK_C, 1'b1, 8'h00, ack, q);
    chk({ack, q}, 9'h159);
    host_u.run_acc(8'hea, RIDX_BANK_A, 1'b0, 8'ha7, ack, q);
    repeat (2) @(posedge clk);
    #1;
    chk(pin_oe[2:0], 3'b101);
    @(posedge clk);
    alt_out[1][11] <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({pin_oe[11], pin_o[11]}, 2'b10);
    // Short pulse must be filtered, a long one must pass
    @(posedge clk);
    pin_i[17] <= 1'b0;
    repeat (5) @(posedge clk);
    pin_i[17] <= 1'b1;
    repeat (12) begin
      @(posedge clk);
      #1;
      chk(grp_irq[1], 1'b0);
    end
    @(posedge clk);
    pin_i[17] <= 1'b0;
    n_evt = 8'h00;
    repeat (20) begin
      @(posedge clk);
      #1;
      n_evt = n_evt + 8'(grp_evt[1]);
    end
    chk(n_evt, 8'h01);
    chk(grp_irq[1], 1'b1);
    // Run access disabled
    @(posedge clk);
    run_en <= 1'b0;
    host_u.io_cyc(8'hea, 1'b1, 8'h00, ack, q);
    chk(ack, 1'b0);
    host_u.run_acc(8'hea, RIDX_WDT, 1'b0, 8'h00, ack, q);
    chk(wdt_ctrl, 8'h5a);
    @(posedge clk);
    run_en <= 1'b1;
    // Relocation through every legal index location
    for (int i = 0; i < 4; i++) begin
      setm(1'b1, 8'he0 + 8'(2 * i) + ((i == 3) ? 8'h04 : 8'h00));
      host_u.io_cyc(idx_base, 1'b1, 8'h00, ack, q);
      chk(ack, 1'b0);
      setm(1'b0, idx_base);
      repeat (2) @(posedge clk);
      host_u.run_acc(idx_base, RIDX_WDT, 1'b1, 8'h00, ack, q);
      chk({ack, q}, 9'h15a);
    end
    setm(1'b1, 8'he6);
    setm(1'b0, 8'he6);
    repeat (2) @(posedge clk);
    host_u.io_cyc(8'he7, 1'b1, 8'h00, ack, q);
    chk(ack, 1'b0);
    host_u.io_cyc(8'hea, 1'b1, 8'h00, ack, q);
    chk({ack, q}, 9'h103);
    results();
  end
endmodule : gpx_top_tb
`default_nettype wire
